// >>> hdl/drive_modbus_command_registers.sv
// Design: Modbus holding register handler with drive command outputs
// ========================================
module drive_modbus_command_registers #(
    parameter int MON_REGS = modbus_regs_pkg::MON_COUNT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Request side from the frame decoder
    input wire logic req_valid,
    input wire modbus_regs_pkg::req_t req,
    input wire logic wr_beat_valid,
    input wire logic [15:0] wr_beat_data,
    output logic req_ready,
    // Answer side to the frame encoder
    output logic rsp_valid,
    output logic rsp_last,
    output logic rsp_exc,
    output logic [15:0] rsp_data,
    input wire logic rsp_ready,
    // Drive configuration and state
    input wire logic modbus_is_fieldbus,
    input wire logic [3:0] command_source_select,
    input wire logic option_module_fitted,
    input wire logic fieldbus_ramp_enable,
    input wire modbus_regs_pkg::drive_status_t drive_status,
    input wire logic [MON_REGS*16-1:0] monitor_words,
    // Commands to the motor control
    output modbus_regs_pkg::drive_cmd_t drive_cmd
);
    import modbus_regs_pkg::*;

    // ========================================
    // Sequencer states and working registers
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WBEAT = 4'b0100,
        ST_ANSWER = 4'b1000
    } state_t;

    state_t state_q;
    logic [15:0] control_q;
    logic [15:0] speed_q;
    logic [15:0] spare_q;
    logic [15:0] ramp_q;
    logic [15:0] addr_q;
    logic [15:0] left_q;
    logic exc_q;
    logic [7:0] exc_code_q;
    logic [15:0] echo_q;
    logic [15:0] rdata_d;
    logic rmapped_d;
    logic bus_owner;
    logic write_ok;
    logic multi_ok;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic [15:0] last_addr;

    // ========================================
    // Register decode used by single and multiple write checks
    function automatic logic is_cmd_reg(input logic [15:0] a);
        is_cmd_reg = (a >= REG_CONTROL) && (a <= REG_RAMP);
    endfunction

    // ========================================
    // Command ownership: Modbus source and no option module
    assign bus_owner = (command_source_select == SRC_MODBUS) && !option_module_fitted;
    assign last_addr = req.addr + req.count - 16'h0001;
    assign multi_ok = (req.count != 16'h0000) && is_cmd_reg(req.addr)
        && is_cmd_reg(last_addr) && (last_addr >= req.addr);
    assign write_ok = is_cmd_reg(req.addr) && modbus_is_fieldbus;

    // ========================================
    // Read decode of one register
    always_comb begin
        rdata_d = 16'h0000;
        rmapped_d = modbus_is_fieldbus;
        if (addr_q == REG_CONTROL) begin
            rdata_d = control_q;
        end else if (addr_q == REG_SPEED) begin
            rdata_d = speed_q;
        end else if (addr_q == REG_SPARE) begin
            rdata_d = spare_q;
        end else if (addr_q == REG_RAMP) begin
            rdata_d = ramp_q;
        end else if (addr_q == REG_STATUS) begin
            rdata_d = drive_status;
            rmapped_d = 1'b1;
        end else if (addr_q > REG_STATUS && addr_q <= REG_MON_LAST) begin
            rdata_d = monitor_words[16*(32'(addr_q) - 32'(REG_STATUS) - 1) +: 16];
            rmapped_d = 1'b1;
        end else begin
            rmapped_d = 1'b0;
        end
    end

    // ========================================
    // Request sequencing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            addr_q <= 16'h0000;
            left_q <= 16'h0000;
            exc_q <= 1'b0;
            exc_code_q <= 8'h00;
            echo_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        addr_q <= req.addr;
                        left_q <= req.count;
                        exc_q <= 1'b0;
                        echo_q <= req.data;
                        if (req.func == FC_READ_MULTI) begin
                            if (req.count == 16'h0000) begin
                                exc_q <= 1'b1;
                                exc_code_q <= EXC_ILLEGAL_VALUE;
                                state_q <= ST_ANSWER;
                            end else begin
                                state_q <= ST_READ;
                            end
                        end else if (req.func == FC_WRITE_SINGLE) begin
                            exc_q <= !write_ok;
                            exc_code_q <= EXC_ILLEGAL_ADDR;
                            if (write_ok && req.addr == REG_RAMP && req.data > RAMP_MAX) begin
                                exc_q <= 1'b1;
                                exc_code_q <= EXC_ILLEGAL_VALUE;
                            end
                            state_q <= ST_ANSWER;
                        end else if (req.func == FC_WRITE_MULTI) begin
                            if (multi_ok && modbus_is_fieldbus) begin
                                state_q <= ST_WBEAT;
                            end else begin
                                exc_q <= 1'b1;
                                exc_code_q <= EXC_ILLEGAL_ADDR;
                                state_q <= ST_ANSWER;
                            end
                        end else begin
                            exc_q <= 1'b1;
                            exc_code_q <= EXC_ILLEGAL_FUNC;
                            state_q <= ST_ANSWER;
                        end
                    end
                end
                ST_READ: begin
                    if (!rmapped_d) begin
                        exc_q <= 1'b1;
                        exc_code_q <= EXC_ILLEGAL_ADDR;
                        state_q <= ST_ANSWER;
                    end else if (rsp_ready) begin
                        addr_q <= addr_q + 16'h0001;
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0001) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_WBEAT: begin
                    if (wr_beat_valid) begin
                        addr_q <= addr_q + 16'h0001;
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0001) begin
                            state_q <= ST_ANSWER;
                        end
                    end
                end
                ST_ANSWER: begin
                    if (rsp_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Write port: single write on acceptance, multi write per beat
    always_comb begin
        wr_en = 1'b0;
        wr_addr = req.addr;
        wr_data = req.data;
        if (state_q == ST_IDLE && req_valid && req.func == FC_WRITE_SINGLE && write_ok) begin
            wr_en = !(req.addr == REG_RAMP && req.data > RAMP_MAX);
        end else if (state_q == ST_WBEAT && wr_beat_valid) begin
            wr_en = !(addr_q == REG_RAMP && wr_beat_data > RAMP_MAX);
            wr_addr = addr_q;
            wr_data = wr_beat_data;
        end
    end

    // ========================================
    // Holding register storage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            control_q <= CONTROL_RESET;
            speed_q <= SPEED_RESET;
            spare_q <= 16'h0000;
            ramp_q <= RAMP_RESET;
        end else if (wr_en) begin
            if (wr_addr == REG_CONTROL) begin
                control_q <= wr_data;
            end else if (wr_addr == REG_SPEED) begin
                speed_q <= wr_data;
            end else if (wr_addr == REG_SPARE) begin
                spare_q <= wr_data;
            end else if (wr_addr == REG_RAMP) begin
                ramp_q <= wr_data;
            end
        end
    end

    // ========================================
    // Drive command outputs from flip-flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            drive_cmd <= '0;
        end else begin
            drive_cmd.run <= bus_owner & control_q[CW_RUN];
            drive_cmd.fast_stop <= bus_owner & control_q[CW_FAST_STOP];
            drive_cmd.fault_reset <= bus_owner & control_q[CW_RESET];
            drive_cmd.coast_stop <= bus_owner & control_q[CW_COAST];
            drive_cmd.speed <= bus_owner ? speed_q : 16'h0000;
            drive_cmd.ramp_valid <= fieldbus_ramp_enable;
            drive_cmd.ramp <= fieldbus_ramp_enable ? ramp_q : 16'h0000;
        end
    end

    // ========================================
    // Answer path; this channel shares no state with any other serial channel
    assign req_ready = (state_q == ST_IDLE);
    assign rsp_valid = (state_q == ST_ANSWER) || (state_q == ST_READ && rmapped_d);
    assign rsp_exc = (state_q == ST_ANSWER) && exc_q;
    // Last flag only means something while a beat is offered
    assign rsp_last = (state_q == ST_ANSWER) || (state_q == ST_READ && left_q == 16'h0001);
    assign rsp_data = (state_q == ST_READ) ? rdata_d
        : (exc_q ? {8'h00, exc_code_q} : echo_q);

    // ========================================
    // Checks: commands follow the holding registers only under the right settings
    a_cmd_gated: assert property (@(posedge core_clk) disable iff (srst)
        !bus_owner |=> !drive_cmd.run)
        else $error("run without ownership");
    a_speed_gated: assert property (@(posedge core_clk) disable iff (srst)
        !bus_owner |=> drive_cmd.speed == 16'h0000)
        else $error("speed without ownership");
    a_run_follows: assert property (@(posedge core_clk) disable iff (srst)
        bus_owner && control_q[CW_RUN] |=> drive_cmd.run)
        else $error("run lost");
    a_stop_bits: assert property (@(posedge core_clk) disable iff (srst)
        bus_owner |=> drive_cmd.fast_stop == $past(control_q[CW_FAST_STOP])
        && drive_cmd.fault_reset == $past(control_q[CW_RESET])
        && drive_cmd.coast_stop == $past(control_q[CW_COAST]))
        else $error("stop bits lost");
    a_fast_stop: assert property (@(posedge core_clk) disable iff (srst)
        drive_cmd.fast_stop |-> $past(control_q[CW_FAST_STOP]))
        else $error("bad fast stop");
    a_reset_bit: assert property (@(posedge core_clk) disable iff (srst)
        drive_cmd.fault_reset |-> $past(control_q[CW_RESET]))
        else $error("bad reset");
    a_coast_bit: assert property (@(posedge core_clk) disable iff (srst)
        drive_cmd.coast_stop |-> $past(control_q[CW_COAST]))
        else $error("bad coast");
    a_speed_follows: assert property (@(posedge core_clk) disable iff (srst)
        bus_owner |=> drive_cmd.speed == $past(speed_q))
        else $error("speed lost");
    // Ramp time checks, independent of the command source
    a_ramp_gate: assert property (@(posedge core_clk) disable iff (srst)
        drive_cmd.ramp_valid |-> $past(fieldbus_ramp_enable))
        else $error("ramp ungated");
    a_ramp_blocked: assert property (@(posedge core_clk) disable iff (srst)
        !fieldbus_ramp_enable |=> !drive_cmd.ramp_valid && drive_cmd.ramp == 16'h0000)
        else $error("ramp leaks");
    a_ramp_follows: assert property (@(posedge core_clk) disable iff (srst)
        fieldbus_ramp_enable |=> drive_cmd.ramp == $past(ramp_q))
        else $error("ramp lost");
    a_ramp_range: assert property (@(posedge core_clk) disable iff (srst)
        ramp_q <= RAMP_MAX)
        else $error("ramp out of range");
    a_ramp_refused: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && req_valid && req.func == FC_WRITE_SINGLE && write_ok
        && req.addr == REG_RAMP && req.data > RAMP_MAX
        |=> exc_q && exc_code_q == EXC_ILLEGAL_VALUE && $stable(ramp_q))
        else $error("ramp over range taken");
    // Request handling checks
    a_read_accept: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && req_valid && req.func == FC_READ_MULTI && req.count != 16'h0000
        |=> state_q == ST_READ && addr_q == $past(req.addr) && left_q == $past(req.count))
        else $error("read not started");
    a_read_step: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_READ && rsp_valid && rsp_ready && left_q != 16'h0001
        |=> state_q == ST_READ && addr_q == $past(addr_q) + 16'h0001)
        else $error("read not consecutive");
    a_single_write: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && req_valid && req.func == FC_WRITE_SINGLE
        && write_ok && req.addr == REG_SPEED |=> speed_q == $past(req.data))
        else $error("single write lost");
    a_write_refused: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && req_valid && req.func == FC_WRITE_SINGLE && !modbus_is_fieldbus
        |=> state_q == ST_ANSWER && exc_q && $stable(control_q) && $stable(speed_q))
        else $error("write while not fieldbus");
    a_multi_accept: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && req_valid && req.func == FC_WRITE_MULTI && multi_ok
        && modbus_is_fieldbus |=> state_q == ST_WBEAT)
        else $error("multi write refused");
    a_multi_reject: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && req_valid && req.func == FC_WRITE_MULTI && !multi_ok
        |=> state_q == ST_ANSWER && exc_q && $stable(control_q))
        else $error("bad multi");
    a_status_read: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_READ && addr_q == REG_STATUS |-> rsp_valid && rsp_data == drive_status)
        else $error("status read");
    a_monitor_read: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ST_READ && addr_q > REG_STATUS && addr_q <= REG_MON_LAST |-> rsp_valid)
        else $error("monitor read");
    // Main scenarios
    c_read_burst: cover property (@(posedge core_clk) state_q == ST_READ && left_q > 16'h0002);
    c_multi_write: cover property (@(posedge core_clk) state_q == ST_WBEAT && wr_beat_valid);
    c_exception: cover property (@(posedge core_clk) rsp_exc && rsp_ready);
    c_status_read: cover property (@(posedge core_clk) state_q == ST_READ && addr_q == REG_STATUS);
    c_owned_run: cover property (@(posedge core_clk) drive_cmd.run && drive_cmd.ramp_valid);
endmodule

// >>> include/modbus_regs_pkg.sv
// Package: register numbers, field positions and types of the drive's Modbus register handler
package modbus_regs_pkg;
    localparam logic [7:0] FC_READ_MULTI = 8'h03;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [15:0] REG_CONTROL = 16'h0001;
    localparam logic [15:0] REG_SPEED = 16'h0002;
    localparam logic [15:0] REG_SPARE = 16'h0003;
    localparam logic [15:0] REG_RAMP = 16'h0004;
    localparam logic [15:0] REG_STATUS = 16'h0006;
    localparam logic [15:0] REG_MON_LAST = 16'h0018;
    localparam logic [15:0] RAMP_MAX = 16'hea60;
    localparam logic [3:0] SRC_MODBUS = 4'h4;
    localparam int CW_RUN = 0;
    localparam int CW_FAST_STOP = 1;
    localparam int CW_RESET = 2;
    localparam int CW_COAST = 3;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] SPEED_RESET = 16'h0000;
    localparam logic [15:0] RAMP_RESET = 16'h01f4;
    localparam int MON_COUNT = 18;

    // Request from the frame decoder, register numbers 1-based
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] count;
        logic [15:0] data;
    } req_t;

    // Drive state shown in the status register
    typedef struct packed {
        logic [7:0] fault_code;
        logic low_high_load;
        logic ready;
        logic standby;
        logic service_due;
        logic inhibit;
        logic hand;
        logic tripped;
        logic running;
    } drive_status_t;

    // Commands issued to the motor control
    typedef struct packed {
        logic run;
        logic fast_stop;
        logic fault_reset;
        logic coast_stop;
        logic [15:0] speed;
        logic ramp_valid;
        logic [15:0] ramp;
    } drive_cmd_t;
endpackage

// >>> bench/modbus_master_model.sv
// Partner: frame decoder and encoder side acting for the bus master
module modbus_master_model
    import modbus_regs_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request side
    output logic req_valid,
    output modbus_regs_pkg::req_t req,
    output logic wr_beat_valid,
    output logic [15:0] wr_beat_data,
    input wire logic req_ready,
    // Answer side
    input wire logic rsp_valid,
    input wire logic rsp_last,
    input wire logic rsp_exc,
    input wire logic [15:0] rsp_data,
    output logic rsp_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Transaction engine
    logic [15:0] rd_q[$];
    logic got_exc;
    bit slow = 0;
    bit hung = 0;
    initial begin
        req_valid = 0;
        req = '0;
        wr_beat_valid = 0;
        wr_beat_data = '1;
        rsp_ready = 0;
    end
    // One request, its write beats, then every answer beat up to the last
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n,
                        input logic [15:0] d, input logic [15:0] wd[$]);
        int k;
        bit done;
        rd_q.delete();
        got_exc = 0;
        done = 0;
        k = 0;
        @(posedge core_clk);
        #1;
        req_valid = 1;
        req = '{func: f, addr: a, count: n, data: d}; // 1-based register numbers
        do begin
            @(negedge core_clk);
            k++;
        end while (!req_ready && k < 100);
        hung |= !req_ready; // A request never taken ends the run as a failure
        @(posedge core_clk);
        #1;
        req_valid = 0;
        req = ~req; // Released fields carry junk
        foreach (wd[i]) begin
            wr_beat_valid = 1;
            wr_beat_data = wd[i];
            @(posedge core_clk);
            #1;
        end
        wr_beat_valid = 0;
        wr_beat_data = ~wr_beat_data;
        k = 0;
        while (!done && k < 200) begin
            rsp_ready = slow ? 1'($urandom_range(0, 1)) : 1'b1;
            @(negedge core_clk);
            if (rsp_valid && rsp_ready) begin
                rd_q.push_back(rsp_data);
                got_exc |= rsp_exc;
                done = rsp_last || rsp_exc;
            end
            @(posedge core_clk);
            #1;
            k++;
        end
        rsp_ready = 0;
        hung |= !done; // An answer without its last beat ends the run as a failure
    endtask
endmodule

// >>> bench/testbench.sv
// Testbench: register handler driven through the master model, answers and commands checked
module testbench import modbus_regs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Signals and instances
    logic core_clk, srst, req_valid, req_ready, wr_beat_valid, rsp_valid, rsp_last, rsp_exc;
    logic rsp_ready, modbus_is_fieldbus, option_module_fitted, fieldbus_ramp_enable;
    logic [3:0] command_source_select;
    logic [15:0] wr_beat_data, rsp_data;
    req_t req;
    drive_status_t drive_status;
    logic [MON_COUNT*16-1:0] monitor_words;
    drive_cmd_t drive_cmd;
    logic [15:0] regs [1:4];
    logic [15:0] wd[$];
    int err_total, comparisons;
    drive_modbus_command_registers i_dut (.core_clk, .srst, .req_valid, .req, .wr_beat_valid,
        .wr_beat_data, .req_ready, .rsp_valid, .rsp_last, .rsp_exc, .rsp_data, .rsp_ready,
        .modbus_is_fieldbus, .command_source_select, .option_module_fitted,
        .fieldbus_ramp_enable, .drive_status, .monitor_words, .drive_cmd);
    modbus_master_model i_master (.core_clk, .req_valid, .req, .wr_beat_valid, .wr_beat_data,
        .req_ready, .rsp_valid, .rsp_last, .rsp_exc, .rsp_data, .rsp_ready);
    initial core_clk = 0;
    always #50 core_clk = ~core_clk;
    // Compare one value, count it, report a mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected word of a readable register
    function automatic logic [15:0] exp_word(input logic [15:0] r);
        if (r <= 4) return regs[r];
        if (r == 6) return drive_status;
        return monitor_words[(r-7)*16 +: 16];
    endfunction
    // Commands after the registers settle
    task automatic chk_cmd();
        logic own;
        repeat (2) @(posedge core_clk);
        #1;
        own = command_source_select == SRC_MODBUS && !option_module_fitted;
        chk({drive_cmd.coast_stop, drive_cmd.fault_reset, drive_cmd.fast_stop, drive_cmd.run},
            own ? regs[1][3:0] : 4'h0);
        chk(drive_cmd.speed, own ? regs[2] : 16'h0000);
        chk(drive_cmd.ramp_valid, fieldbus_ramp_enable);
        if (fieldbus_ramp_enable) chk(drive_cmd.ramp, regs[4]);
        else chk(drive_cmd.ramp, 16'h0000);
    endtask
    task automatic wr06(input logic [15:0] a, input logic [15:0] d, input logic [7:0] exc);
        wd.delete();
        i_master.xfer(FC_WRITE_SINGLE, a, 16'h0001, d, wd);
        chk(16'(i_master.rd_q.size()), 16'h0001);
        chk(i_master.rd_q[0], exc != 0 ? {8'h00, exc} : d);
        chk(i_master.got_exc, exc != 0);
        if (exc == 0) regs[a] = d;
    endtask
    task automatic wr16(input logic [15:0] a, input logic [15:0] n, input logic [7:0] exc);
        i_master.xfer(FC_WRITE_MULTI, a, n, 16'h0000, wd);
        chk(i_master.got_exc, exc != 0);
        if (exc != 0) chk(i_master.rd_q[0], exc);
        else foreach (wd[i]) regs[a + i] = wd[i];
    endtask
    task automatic rd03(input logic [15:0] a, input logic [15:0] n);
        wd.delete();
        i_master.xfer(FC_READ_MULTI, a, n, 16'h0000, wd);
        chk(16'(i_master.rd_q.size()), n);
        chk(i_master.got_exc, 1'b0);
        foreach (i_master.rd_q[i]) chk(i_master.rd_q[i], exp_word(a + 16'(i)));
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #2000000;
        err_total++;
        tally_and_finish();
    end
    // A handshake limit in the master model that runs out ends the run as a failure
    always @(posedge i_master.hung) begin
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        err_total = 0;
        comparisons = 0;
        srst = 1;
        modbus_is_fieldbus = 1;
        command_source_select = SRC_MODBUS;
        option_module_fitted = 0;
        fieldbus_ramp_enable = 0;
        drive_status = '0;
        monitor_words = '0;
        void'($urandom(7));
        regs = '{CONTROL_RESET, SPEED_RESET, 16'h0000, RAMP_RESET};
        repeat (10) @(posedge core_clk);
        #1;
        chk({req_ready, rsp_valid, |drive_cmd}, 3'b100);
        srst = 0;
        fieldbus_ramp_enable = 1;
        rd03(REG_CONTROL, 16'h0004);
        for (int b = 0; b < 4; b++) begin
            wr06(REG_CONTROL, 16'h0001 << b, 8'h00);
            chk_cmd();
        end
        wr06(REG_CONTROL, 16'h0000, 8'h00); // Coast bit cleared
        wr06(REG_SPEED, 16'd500, 8'h00); // 50.0 Hz
        wr06(REG_RAMP, RAMP_MAX, 8'h00);
        wr06(REG_RAMP, RAMP_MAX + 16'h0001, EXC_ILLEGAL_VALUE);
        wr06(16'h0005, 16'h1234, EXC_ILLEGAL_ADDR);
        chk_cmd();
        // Random configurations and multi-register writes, slow answer side
        i_master.slow = 1;
        repeat (12) begin
            command_source_select = $urandom_range(0, 1) ? SRC_MODBUS : 4'($urandom_range(0, 3));
            option_module_fitted = $urandom_range(0, 3) == 0;
            fieldbus_ramp_enable = 1'($urandom_range(0, 1));
            wd.delete();
            repeat ($urandom_range(1, 4)) wd.push_back(16'($urandom_range(0, 60000)));
            wr16(16'(5 - wd.size()), 16'(wd.size()), 8'h00);
            rd03(REG_CONTROL, 16'h0004);
            chk_cmd();
        end
        wd.delete();
        wr16(16'h0003, 16'h0003, EXC_ILLEGAL_ADDR);
        wr16(16'h0001, 16'h0000, EXC_ILLEGAL_ADDR);
        rd03(REG_CONTROL, 16'h0004); // Nothing changed
        // Monitoring block under a foreign command source
        command_source_select = 4'h0;
        drive_status = 16'($urandom);
        for (int k = 0; k < MON_COUNT; k++) monitor_words[k*16 +: 16] = 16'($urandom);
        rd03(REG_STATUS, 16'd19);
        // Named status flags must land on their fixed bit positions
        drive_status = '0;
        drive_status.fault_code = 8'h2a;
        {drive_status.ready, drive_status.hand, drive_status.tripped, drive_status.running} = 4'hf;
        rd03(REG_STATUS, 16'h0001);
        chk(i_master.rd_q[0], 16'h2a47); // Fault number high, flags on bits 6, 2, 1, 0
        i_master.xfer(8'h05, REG_CONTROL, 16'h0001, 16'h0000, wd);
        chk(i_master.rd_q[0], EXC_ILLEGAL_FUNC); // Only codes 03, 06 and 16
        chk(i_master.got_exc, 1'b1);
        modbus_is_fieldbus = 0;
        wr06(REG_SPEED, 16'd250, EXC_ILLEGAL_ADDR);
        rd03(REG_STATUS, 16'h0002);
        tally_and_finish();
    end
endmodule
